//--- common/qps_pkg.sv
// Shared constants and types for the quad pot two-wire slave
package qps_pkg;

  // ==========================================================
  // Clock and timing
  localparam int SYS_CLK_HZ       = 20_000_000;
  localparam int NV_WRITE_TIME_US = 5000;
  localparam int NV_WRITE_CYCLES  = NV_WRITE_TIME_US * (SYS_CLK_HZ / 1_000_000);

  // ==========================================================
  // Array geometry
  localparam int POT_COUNT  = 4;
  localparam int REG_COUNT  = 4;
  localparam int WIPER_BITS = 8;
  localparam int TAP_COUNT  = 256;

  // ==========================================================
  // Byte framing and field positions
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam int         ADDR_TYPE_HI = 7;
  localparam int         ADDR_TYPE_LO = 4;
  localparam int         ADDR_PIN_HI  = 3;
  localparam int         ADDR_PIN_LO  = 0;
  localparam int         CMD_OP_HI    = 7;
  localparam int         CMD_OP_LO    = 4;
  localparam int         CMD_REG_HI   = 3;
  localparam int         CMD_REG_LO   = 2;
  localparam int         CMD_POT_HI   = 1;
  localparam int         CMD_POT_LO   = 0;

  // ==========================================================
  // Instruction codes, upper nibble of the command byte
  localparam logic [3:0] OP_RD_WIPER  = 4'h9;
  localparam logic [3:0] OP_WR_WIPER  = 4'hA;
  localparam logic [3:0] OP_RD_STORE  = 4'hB;
  localparam logic [3:0] OP_WR_STORE  = 4'hC;
  localparam logic [3:0] OP_STORE2WIP = 4'hD;
  localparam logic [3:0] OP_WIP2STORE = 4'hE;
  localparam logic [3:0] OP_G_ST2WIP  = 4'h1;
  localparam logic [3:0] OP_G_WIP2ST  = 4'h8;

  // ==========================================================
  // Reset values
  localparam logic [7:0] STORE_RESET_VAL = 8'h80;
  localparam logic [6:0] SYNC_RESET_VAL  = 7'h7F;

  // ==========================================================
  // Serial engine states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
    ST_RX, ST_RX_ACK, ST_TX, ST_WAIT
  } qps_state_t;

endpackage

//--- logic/qps_tap_decoder.sv
// Registered one-hot tap switch decoder for one resistor array
`timescale 1ns/1ns
module qps_tap_decoder import qps_pkg::*; #(
  parameter int POS_BITS = WIPER_BITS,
  parameter int TAPS     = TAP_COUNT
) (
  input  wire logic                sys_clk,   // System clock
  input  wire logic                sys_rst,   // Synchronous reset
  input  wire logic [POS_BITS-1:0] position,  // Wiper position
  output logic      [TAPS-1:0]     tap_sel    // One-hot tap switches
);

  localparam logic [TAPS-1:0] RESET_SEL = {{(TAPS-1){1'b0}}, 1'b1};

  logic [TAPS-1:0] sel_next;

  // ==========================================================
  // Decode: one compare per tap switch
  genvar t;
  generate
    for (t = 0; t < TAPS; t++) begin : g_tap
      assign sel_next[t] = (position == POS_BITS'(t));
    end
  endgenerate

  // Register the switch enables
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tap_sel <= RESET_SEL;
    end else begin
      tap_sel <= sel_next;
    end
  end

endmodule

//--- logic/qps_slave.sv
// Two-wire slave front end of a quad digital potentiometer
// Notes on behaviour
// - Low address nibble comes from the four address select pins.
// - High address nibble is a fixed type code compared with the input.
// - Address acknowledged only when all four pin bits match.
// - Write lock low refuses every nonvolatile stored-setting write.
// - Data changes only while SCL is low; high changes mean start or stop.
// - Start detected at all times; nothing answered before a start.
// - Transmitter releases SDA after eight bits; receiver acks on ninth.
// - Ack after address, after command byte, and after a data byte.
// - Each wiper position decodes into one of 256 one-hot tap switches.
// - Each array has 255 segments with 256 tap switches.
// - Wiper written directly or loaded from stored settings; all readable.
// - Stop after a nonvolatile write command starts the internal write.
// - Address not acked during the internal write; acked after it.
// - After power up each wiper is loaded from its first stored setting.
// - Command byte: instruction nibble, register select, pot select.
`timescale 1ns/1ns
module qps_slave import qps_pkg::*; #(
  parameter logic [3:0] TYPE_CODE = 4'hA,           // Arbitrary value
  parameter int         NV_CYCLES = NV_WRITE_CYCLES // Internal write length
) (
  input  wire logic       sys_clk,             // System clock, 20 MHz
  input  wire logic       sys_rst,             // Synchronous reset
  input  wire logic       scl_pin,             // Serial clock from master
  input  wire logic       sda_in,              // Serial data line level
  output logic            sda_out,             // Serial data drive value
  output logic            sda_oe,              // Serial data drive enable
  input  wire logic [3:0] address_select_pins, // Low address nibble
  input  wire logic       write_lock_n,        // Low blocks nv writes
  output logic [3:0][255:0] tap_select,        // One-hot taps per pot
  output logic [3:0][7:0] wiper_position,      // Wiper position registers
  output logic            nv_busy              // Internal write running
);

  localparam int BUSY_W = $clog2(NV_CYCLES + 1);
  localparam logic [BUSY_W-1:0] BUSY_LAST = BUSY_W'(NV_CYCLES - 1);

  // ==========================================================
  // Input synchronisers
  logic [6:0] in_meta_reg;
  logic [6:0] in_sync_reg;
  logic       scl_prev_reg;
  logic       sda_prev_reg;

  // Two flops on every pin, then one delay stage for edges
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      in_meta_reg  <= SYNC_RESET_VAL;
      in_sync_reg  <= SYNC_RESET_VAL;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      in_meta_reg  <= {write_lock_n, address_select_pins, sda_in, scl_pin};
      in_sync_reg  <= in_meta_reg;
      scl_prev_reg <= in_sync_reg[0];
      sda_prev_reg <= in_sync_reg[1];
    end
  end

  wire       scl_s    = in_sync_reg[0];
  wire       sda_s    = in_sync_reg[1];
  wire [3:0] addr_s   = in_sync_reg[5:2];
  wire       lock_n_s = in_sync_reg[6];

  // ==========================================================
  // Bus condition detection
  // SDA moving while SCL stays high marks start or stop
  wire start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  wire stop_det  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
  wire scl_rise  = scl_s & ~scl_prev_reg;
  wire scl_fall  = ~scl_s & scl_prev_reg;

  // ==========================================================
  // Serial engine registers
  qps_state_t state_reg, state_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [7:0] tx_reg, tx_next;
  logic       oe_reg, oe_next;
  logic       busy_reg;
  logic [BUSY_W-1:0] busy_cnt_reg;

  // Storage
  logic [7:0] wcr_reg [POT_COUNT];
  logic [7:0] store_reg [POT_COUNT*REG_COUNT];
  logic       init_reg;

  // Pending nonvolatile write
  logic       pend_reg;
  logic       pend_global_reg;
  logic       pend_from_wcr_reg;
  logic [1:0] pend_sel_reg;
  logic [1:0] pend_pot_reg;
  logic [7:0] pend_data_reg;

  // ==========================================================
  // Address and command decode
  wire byte_done  = scl_fall & (bit_cnt_reg == BYTE_BITS);
  wire type_match = shift_reg[ADDR_TYPE_HI:ADDR_TYPE_LO] == TYPE_CODE;
  wire pins_match = shift_reg[ADDR_PIN_HI:ADDR_PIN_LO] == addr_s;
  wire addr_ack   = type_match & pins_match & ~busy_reg;

  // Fields of the byte just received, for the command phase
  wire [3:0] in_op  = shift_reg[CMD_OP_HI:CMD_OP_LO];
  wire [1:0] in_sel = shift_reg[CMD_REG_HI:CMD_REG_LO];
  wire [1:0] in_pot = shift_reg[CMD_POT_HI:CMD_POT_LO];

  // Fields of the latched command, for the data phase
  wire [3:0] c_op  = cmd_reg[CMD_OP_HI:CMD_OP_LO];
  wire [1:0] c_sel = cmd_reg[CMD_REG_HI:CMD_REG_LO];
  wire [1:0] c_pot = cmd_reg[CMD_POT_HI:CMD_POT_LO];

  wire c_is_read  = (c_op == OP_RD_WIPER) | (c_op == OP_RD_STORE);
  wire c_is_3byte = c_is_read | (c_op == OP_WR_WIPER) |
                    (c_op == OP_WR_STORE);
  wire in_valid   = (in_op == OP_RD_WIPER)  | (in_op == OP_WR_WIPER)  |
                    (in_op == OP_RD_STORE)  | (in_op == OP_WR_STORE)  |
                    (in_op == OP_STORE2WIP) | (in_op == OP_WIP2STORE) |
                    (in_op == OP_G_ST2WIP)  | (in_op == OP_G_WIP2ST);

  wire in_cmd_done = byte_done & (state_reg == ST_CMD) & in_valid;
  wire rx_done     = byte_done & (state_reg == ST_RX);

  // Readback of wiper or stored setting
  wire [7:0] rd_data = (c_op == OP_RD_WIPER) ? wcr_reg[c_pot] :
                       store_reg[{c_pot, c_sel}];

  // Register-changing events
  wire xfr_now   = in_cmd_done &
                   ((in_op == OP_STORE2WIP) | (in_op == OP_G_ST2WIP));
  wire xfr_glob  = in_op == OP_G_ST2WIP;
  wire wcr_write = rx_done & (c_op == OP_WR_WIPER);
  wire pend_cmd  = in_cmd_done &
                   ((in_op == OP_WIP2STORE) | (in_op == OP_G_WIP2ST));
  wire pend_rx   = rx_done & (c_op == OP_WR_STORE);
  wire commit    = stop_det & pend_reg & lock_n_s;

  // ==========================================================
  // Serial engine next state
  always_comb begin
    state_next   = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next   = shift_reg;
    cmd_next     = cmd_reg;
    tx_next      = tx_reg;
    oe_next      = oe_reg;
    if (start_det) begin
      state_next   = ST_ADDR;
      bit_cnt_next = 4'h0;
      oe_next      = 1'b0;
    end else if (stop_det) begin
      state_next = ST_IDLE;
      oe_next    = 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR, ST_CMD, ST_RX: begin
          if (scl_rise) begin
            shift_next   = {shift_reg[6:0], sda_s};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            bit_cnt_next = 4'h0;
            if (state_reg == ST_ADDR) begin
              oe_next    = addr_ack;
              state_next = addr_ack ? ST_ADDR_ACK : ST_WAIT;
            end else if (state_reg == ST_CMD) begin
              cmd_next   = shift_reg;
              oe_next    = in_valid;
              state_next = in_valid ? ST_CMD_ACK : ST_WAIT;
            end else begin
              oe_next    = 1'b1;
              state_next = ST_RX_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            oe_next    = 1'b0;
            state_next = ST_CMD;
          end
        end
        ST_CMD_ACK: begin
          if (scl_fall) begin
            bit_cnt_next = 4'h0;
            if (c_is_read) begin
              tx_next    = rd_data;
              oe_next    = ~rd_data[7];
              state_next = ST_TX;
            end else begin
              oe_next    = 1'b0;
              state_next = c_is_3byte ? ST_RX : ST_WAIT;
            end
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            oe_next    = 1'b0;
            state_next = ST_WAIT;
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_reg == BYTE_BITS) begin
              oe_next    = 1'b0;
              state_next = ST_WAIT;
            end else begin
              tx_next = {tx_reg[6:0], 1'b0};
              oe_next = ~tx_reg[6];
            end
          end
        end
        default: begin
          state_next = state_reg;
        end
      endcase
    end
  end

  // Serial engine state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      cmd_reg     <= 8'h00;
      tx_reg      <= 8'h00;
      oe_reg      <= 1'b0;
    end else begin
      state_reg   <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg   <= shift_next;
      cmd_reg     <= cmd_next;
      tx_reg      <= tx_next;
      oe_reg      <= oe_next;
    end
  end

  // ==========================================================
  // Pending nonvolatile write, committed at the stop
  always_ff @(posedge sys_clk) begin
    if (sys_rst || start_det || stop_det) begin
      pend_reg          <= 1'b0;
      pend_global_reg   <= 1'b0;
      pend_from_wcr_reg <= 1'b0;
      pend_sel_reg      <= 2'h0;
      pend_pot_reg      <= 2'h0;
      pend_data_reg     <= 8'h00;
    end else if (pend_cmd) begin
      pend_reg          <= 1'b1;
      pend_global_reg   <= in_op == OP_G_WIP2ST;
      pend_from_wcr_reg <= 1'b1;
      pend_sel_reg      <= in_sel;
      pend_pot_reg      <= in_pot;
    end else if (pend_rx) begin
      pend_reg          <= 1'b1;
      pend_global_reg   <= 1'b0;
      pend_from_wcr_reg <= 1'b0;
      pend_sel_reg      <= c_sel;
      pend_pot_reg      <= c_pot;
      pend_data_reg     <= shift_reg;
    end
  end

  // Internal write timer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      busy_reg     <= 1'b0;
      busy_cnt_reg <= '0;
    end else if (commit) begin
      busy_reg     <= 1'b1;
      busy_cnt_reg <= '0;
    end else if (busy_reg) begin
      busy_reg     <= busy_cnt_reg != BUSY_LAST;
      busy_cnt_reg <= busy_cnt_reg + 1'b1;
    end
  end

  // Power-up load marker
  always_ff @(posedge sys_clk) begin
    init_reg <= sys_rst;
  end

  // ==========================================================
  // Stored settings and wiper registers, per entry
  genvar e, p;
  generate
    for (e = 0; e < POT_COUNT*REG_COUNT; e++) begin : g_store
      wire st_we = commit & (pend_sel_reg == 2'(e % REG_COUNT)) &
                   (pend_global_reg | (pend_pot_reg == 2'(e / REG_COUNT)));
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          store_reg[e] <= STORE_RESET_VAL;
        end else if (st_we) begin
          store_reg[e] <= pend_from_wcr_reg ?
                          wcr_reg[e / REG_COUNT] : pend_data_reg;
        end
      end
    end
    for (p = 0; p < POT_COUNT; p++) begin : g_pot
      wire wr_hit  = wcr_write & (c_pot == 2'(p));
      wire xfr_hit = xfr_now & (xfr_glob | (in_pot == 2'(p)));
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          wcr_reg[p] <= STORE_RESET_VAL;
        end else if (init_reg) begin
          wcr_reg[p] <= store_reg[p*REG_COUNT];
        end else if (wr_hit) begin
          wcr_reg[p] <= shift_reg;
        end else if (xfr_hit) begin
          wcr_reg[p] <= store_reg[p*REG_COUNT + int'(in_sel)];
        end
      end
      assign wiper_position[p] = wcr_reg[p];
      qps_tap_decoder #(
        .POS_BITS (WIPER_BITS),
        .TAPS     (TAP_COUNT)
      ) u_dec (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .position (wcr_reg[p]),
        .tap_sel  (tap_select[p])
      );
    end
  endgenerate

  // ==========================================================
  // Outputs; open drain line only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe  = oe_reg;
  assign nv_busy = busy_reg;

endmodule

//--- test/qps_slave_assertions.sv
// Concurrent checks on the quad pot two-wire slave ports
`timescale 1ns/1ns
module qps_slave_checker import qps_pkg::*; #(
  parameter int NV_CYCLES = NV_WRITE_CYCLES
) (
  input wire logic             sys_clk,             // System clock
  input wire logic             sys_rst,             // Synchronous reset
  input wire logic             scl_pin,             // Serial clock
  input wire logic             sda_in,              // Data line level
  input wire logic             sda_out,             // Data drive value
  input wire logic             sda_oe,              // Data drive enable
  input wire logic [3:0]       address_select_pins, // Low address nibble
  input wire logic             write_lock_n,        // Low blocks nv writes
  input wire logic [3:0][255:0] tap_select,         // One-hot taps
  input wire logic [3:0][7:0]  wiper_position,      // Wiper registers
  input wire logic             nv_busy              // Internal write
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // Busy length counter
  logic [31:0] busy_cnt_reg;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !nv_busy) busy_cnt_reg <= '0;
    else busy_cnt_reg <= busy_cnt_reg + 32'h0000_0001;
  end

  // ==========================================================
  // Tap decoding per pot
  for (genvar p = 0; p < 4; p++) begin : g_pot
    a_tap_onehot: assert property ($onehot(tap_select[p]))
      else $error("tap select not one-hot");
    a_tap_follow: assert property (
      !$past(sys_rst) |-> tap_select[p] == 256'h1 << $past(wiper_position[p]))
      else $error("tap select does not follow wiper");
  end

  // ==========================================================
  // Serial line and write cycle relations
  a_reset_quiet: assert property (disable iff (1'b0)
    sys_rst |=> !sda_oe && !nv_busy && wiper_position[0] == STORE_RESET_VAL)
    else $error("reset state wrong");
  a_oe_scl_low: assert property (
    $changed(sda_oe) |-> !$past(scl_pin) && !$past(scl_pin, 3))
    else $error("data drive changed while clock high");
  a_wiper_clock: assert property (
    $changed(wiper_position) && !$past(sys_rst, 2) |-> !$past(scl_pin, 2))
    else $error("wiper changed outside clock low");
  a_busy_length: assert property (
    $fell(nv_busy) |-> busy_cnt_reg == NV_CYCLES)
    else $error("write cycle length wrong");
  a_busy_stop: assert property (
    $rose(nv_busy) |-> scl_pin && sda_in && !$past(sda_in, 7))
    else $error("write cycle began without a stop");
  a_busy_lock: assert property (
    $rose(nv_busy) |-> write_lock_n && $past(write_lock_n, 8))
    else $error("write cycle began while locked");
  a_drive_low: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  a_busy_quiet: assert property (
    nv_busy && $past(nv_busy) |-> !$rose(sda_oe))
    else $error("acknowledge during write cycle");

  // Main scenarios reached
  c_busy: cover property ($rose(nv_busy));
  c_ack: cover property ($rose(sda_oe));
  c_wiper: cover property ($changed(wiper_position));
endmodule

bind qps_slave qps_slave_checker #(.NV_CYCLES(NV_CYCLES)) qps_slave_checker_i (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .scl_pin(scl_pin),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .address_select_pins(address_select_pins), .write_lock_n(write_lock_n),
  .tap_select(tap_select), .wiper_position(wiper_position),
  .nv_busy(nv_busy));

//--- test/qps_master_model.sv
// Two-wire bus master model that clocks and frames every transfer
`timescale 1ns/1ns
module qps_master_model (
  input  wire logic sys_clk,  // Bench clock
  input  wire logic sda_line, // Resolved data line
  output logic      scl_pin,  // Serial clock, high when idle
  output logic      sda_low   // High pulls data low
);
  // ==========================================================
  // Idle bus, clock stands high between frames
  initial begin
    scl_pin = 1'b1;
    sda_low = 1'b0;
  end

  // Wait whole clocks
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Start, data falls while clock high
  task automatic start();
    sda_low <= 1'b0;
    scl_pin <= 1'b1;
    tick(4);
    sda_low <= 1'b1;
    tick(4);
    scl_pin <= 1'b0;
  endtask

  // One bit, data set in low phase, sampled in high phase
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    sda_low <= ~b;
    tick(2);
    scl_pin <= 1'b1;
    tick(2);
    r = sda_line;
    tick(2);
    scl_pin <= 1'b0;
  endtask

  // Stop, data rises while clock high
  task automatic stop();
    tick(2);
    sda_low <= 1'b1;
    tick(2);
    scl_pin <= 1'b1;
    tick(4);
    sda_low <= 1'b0;
    tick(4);
  endtask

  // Byte out MSB first, line released for the ninth clock
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Byte in MSB first, master answers on the ninth clock
  task automatic get_byte(output logic [7:0] d, input logic mack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~mack, r);
  endtask
endmodule

//--- test/qps_slave_bench.sv
// Self-checking bench for the quad pot two-wire slave
`timescale 1ns/1ns
module qps_slave_bench import qps_pkg::*; ;
  localparam logic [3:0] TYPE = 4'h6; // Arbitrary type code
  localparam int         NV   = 200;
  logic              sys_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic [3:0]        pins    = 4'h9;
  logic              lock_n  = 1'b1;
  logic              scl, m_low, sda_oe, sda_out, nv_busy;
  logic [3:0][255:0] tap_select;
  logic [3:0][7:0]   wiper_position;
  logic [7:0]        vals [4] = '{8'h00, 8'hFF, 8'h01, 8'hA5};
  int                num_errors = 0;
  int                num_checks = 0;
  // Open drain line with pull-up
  wire sda_line = ~(m_low | (sda_oe & ~sda_out));

  // ==========================================================
  // Design and bus master
  qps_slave #(.TYPE_CODE(TYPE), .NV_CYCLES(NV)) qps_slave_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .scl_pin(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_select_pins(pins), .write_lock_n(lock_n),
    .tap_select(tap_select), .wiper_position(wiper_position),
    .nv_busy(nv_busy));
  qps_master_model qps_master_model_i (
    .sys_clk(sys_clk), .sda_line(sda_line), .scl_pin(scl),
    .sda_low(m_low));

  // Clock
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Shared tasks
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic check(input logic [255:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic frame(input logic [7:0] a, c, d, input int nb,
                       output logic [2:0] k);
    qps_master_model_i.start();
    qps_master_model_i.put_byte(a, k[2]);
    qps_master_model_i.put_byte(c, k[1]);
    k[0] = 1'b0;
    if (nb > 2) qps_master_model_i.put_byte(d, k[0]);
    qps_master_model_i.stop();
  endtask
  task automatic rd(input logic [7:0] c, output logic [7:0] v);
    logic [1:0] k;
    qps_master_model_i.start();
    qps_master_model_i.put_byte({TYPE, pins}, k[1]);
    qps_master_model_i.put_byte(c, k[0]);
    qps_master_model_i.get_byte(v, 1'b0);
    qps_master_model_i.stop();
    check(k, 2'b11);
  endtask
  task automatic poll(output logic ack);
    qps_master_model_i.start();
    qps_master_model_i.put_byte({TYPE, pins}, ack);
    qps_master_model_i.stop();
  endtask
  // Bounded polling until the address is acknowledged again
  task automatic wait_ready();
    logic a;
    int   n;
    a = 1'b0;
    n = 0;
    while (a !== 1'b1 && n < 10) begin
      poll(a);
      n++;
    end
    check(a, 1'b1);
    if (a !== 1'b1) results();
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    cyc(4);
    for (int p = 0; p < 4; p++) begin
      check(wiper_position[p], STORE_RESET_VAL);
      check(tap_select[p], 256'h1 << STORE_RESET_VAL);
    end
  endtask
  task automatic t_wiper();
    logic [7:0] r;
    logic [2:0] k;
    for (int p = 0; p < 4; p++) begin
      frame({TYPE, pins}, {OP_WR_WIPER, 2'b00, 2'(p)}, vals[p], 3, k);
      check(k, 3'b111);
      cyc(2);
      check(wiper_position[p], vals[p]);
      check(tap_select[p], 256'h1 << vals[p]);
      rd({OP_RD_WIPER, 2'b00, 2'(p)}, r);
      check(r, vals[p]);
    end
  endtask
  task automatic t_mismatch();
    logic [2:0] k;
    frame({TYPE, ~pins}, {OP_WR_WIPER, 4'h0}, 8'h33, 3, k);
    check(k, 3'b000);
    frame({4'h9, pins}, {OP_WR_WIPER, 4'h0}, 8'h33, 3, k);
    check(k, 3'b000);
    check(wiper_position[0], vals[0]);
    @(posedge sys_clk);
    pins <= 4'h3;
    cyc(8);
    frame({TYPE, 4'h3}, {OP_WR_WIPER, 4'h0}, 8'h5A, 3, k);
    check(k, 3'b111);
    check(wiper_position[0], 8'h5A);
  endtask
  task automatic t_store();
    logic [2:0] k;
    logic [7:0] r;
    logic       a;
    int         n;
    frame({TYPE, pins}, {OP_WR_STORE, 4'b1001}, 8'hC3, 3, k);
    check(k, 3'b111);
    cyc(4);
    check(nv_busy, 1'b1);
    poll(a);
    check(a, 1'b0);
    n = 0;
    while (a !== 1'b1 && n < 10) begin
      poll(a);
      n++;
    end
    check(a, 1'b1);
    if (a !== 1'b1) results();
    check(nv_busy, 1'b0);
    rd({OP_RD_STORE, 4'b1001}, r);
    check(r, 8'hC3);
    frame({TYPE, pins}, {OP_STORE2WIP, 4'b1001}, 8'h00, 2, k);
    check(k[2:1], 2'b11);
    check(wiper_position[1], 8'hC3);
  endtask
  task automatic t_lock();
    logic [2:0] k;
    logic [7:0] r;
    @(posedge sys_clk);
    lock_n <= 1'b0;
    frame({TYPE, pins}, {OP_WR_STORE, 4'b1110}, 8'h11, 3, k);
    cyc(4);
    check(nv_busy, 1'b0);
    rd({OP_RD_STORE, 4'b1110}, r);
    check(r, STORE_RESET_VAL);
    @(posedge sys_clk);
    lock_n <= 1'b1;
  endtask
  // Global and single transfers between wipers and stored settings
  task automatic t_global();
    logic [2:0] k;
    logic [7:0] r;
    frame({TYPE, pins}, {OP_G_WIP2ST, 4'b0100}, 8'h00, 2, k);
    check(k[2:1], 2'b11);
    wait_ready();
    frame({TYPE, pins}, {OP_WR_WIPER, 4'b0010}, 8'h3C, 3, k);
    check(wiper_position[2], 8'h3C);
    frame({TYPE, pins}, {OP_G_ST2WIP, 4'b0100}, 8'h00, 2, k);
    check(k[2:1], 2'b11);
    check(wiper_position[2], 8'h01);
    check(wiper_position[1], 8'hC3);
    frame({TYPE, pins}, {OP_WIP2STORE, 4'b1111}, 8'h00, 2, k);
    check(k[2:1], 2'b11);
    wait_ready();
    rd({OP_RD_STORE, 4'b1111}, r);
    check(r, 8'hA5);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_wiper();
    t_mismatch();
    t_store();
    t_lock();
    t_global();
    results();
  end
endmodule
